// *** src/lfo_defs.svh ***
// register indexes, field positions, reset values and timing counts
`ifndef LFO_DEFS_SVH
`define LFO_DEFS_SVH
`define LFO_IDX_LF_CTRL    8'h86
`define LFO_IDX_HF_TRIM    8'hb3
`define LFO_IDX_IRQ_STAT   8'hc0
`define LFO_IDX_IRQ_EN     8'hc1
`define LFO_IDX_IRQ_CLR    8'hc2
`define LFO_IDX_CAP_CTRL   8'hc3
`define LFO_IDX_RELOAD_A   8'hc4
`define LFO_IDX_RELOAD_B   8'hc5
`define LFO_IDX_COUNT_A    8'hc6
`define LFO_IDX_COUNT_B    8'hc7
`define LFO_LF_EN_BIT      7
`define LFO_LF_RDY_BIT     6
`define LFO_LF_TRIM_LSB    2
`define LFO_LF_DIV_LSB     0
`define LFO_HF_TRIM_W      5
`define LFO_HF_TRIM_RESET  5'h10
`define LFO_LF_CTRL_RESET  8'h00
`define LFO_IRQ_CAP_A      0
`define LFO_IRQ_CAP_B      1
`define LFO_IRQ_READY      2
`define LFO_IRQ_W          3
`define LFO_PCLK_HZ        10000000
`define LFO_LF_NOM_HZ      80000
`define LFO_HALF_CYC       (`LFO_PCLK_HZ / (2 * `LFO_LF_NOM_HZ))
`define LFO_SETTLE_EDGES   4
`endif

// *** src/lfo_pkg.sv ***
// types shared by the oscillator control block
package lfo_pkg;
    typedef enum logic [1:0] {
        LFO_OFF    = 2'b00,
        LFO_SETTLE = 2'b01,
        LFO_RUN    = 2'b11
    } lfo_state_t;
    typedef logic [1:0] lfo_div_t;
endpackage

// *** src/lfo_osc_if.sv ***
// link between register block and low-frequency oscillator model
`timescale 1ns/1ps
interface lfo_osc_if;
    logic                enable;
    logic [3:0]          trim;
    lfo_pkg::lfo_div_t   div_sel;
    logic                ready;
    logic                out_level;
    logic                rise;
    logic                fall;
    modport ctrl (output enable, output trim, output div_sel,
                  input ready, input out_level, input rise, input fall);
    modport core (input enable, input trim, input div_sel,
                  output ready, output out_level, output rise, output fall);
endinterface

// *** src/lfo_osc_core.sv ***
// low-frequency oscillator model with trim, divider and settle tracking
`timescale 1ns/1ps
`include "lfo_defs.svh"
module lfo_osc_core
(
    input wire logic   pclk,
    input wire logic   presetn,
    lfo_osc_if.core    osc
);
    lfo_pkg::lfo_state_t state_reg;
    lfo_pkg::lfo_state_t state_next;
    logic [6:0]          hcnt_reg;
    logic [6:0]          half_len;
    logic                raw_reg;
    logic [2:0]          hdiv_reg;
    logic [2:0]          settle_reg;
    logic                half_tick;
    logic                out_tgl;
    logic                running;

    // divide by mask+1 raw half periods per output half period
    function automatic logic [2:0] div_mask(input lfo_pkg::lfo_div_t sel);
        div_mask = (sel == 2'b00) ? 3'h7 : (sel == 2'b01) ? 3'h3 : (sel == 2'b10) ? 3'h1 : 3'h0;
    endfunction

    // larger trim stretches the half period, so 0 is fastest
    assign half_len  = 7'(`LFO_HALF_CYC) + {3'h0, osc.trim};
    assign running   = (state_reg != lfo_pkg::LFO_OFF);
    assign half_tick = running && (hcnt_reg >= half_len - 7'h1); // lowered trim ends the half at once
    assign out_tgl   = half_tick && ((hdiv_reg & div_mask(osc.div_sel)) == div_mask(osc.div_sel));

    // enable gates everything; leaving off drops ready at once
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            lfo_pkg::LFO_OFF:    if (osc.enable) state_next = lfo_pkg::LFO_SETTLE;
            lfo_pkg::LFO_SETTLE: if (!osc.enable) state_next = lfo_pkg::LFO_OFF;
                                 else if (settle_reg == 3'(`LFO_SETTLE_EDGES)) state_next = lfo_pkg::LFO_RUN;
            lfo_pkg::LFO_RUN:    if (!osc.enable) state_next = lfo_pkg::LFO_OFF;
            default:             state_next = lfo_pkg::LFO_OFF;
        endcase
    end

    // oscillator counters; the output idles low while off, with no edge pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg     <= lfo_pkg::LFO_OFF;
            hcnt_reg      <= 7'h0;
            raw_reg       <= 1'b0;
            hdiv_reg      <= 3'h0;
            settle_reg    <= 3'h0;
            osc.ready     <= 1'b0;
            osc.out_level <= 1'b0;
            osc.rise      <= 1'b0;
            osc.fall      <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            hcnt_reg      <= (!running || half_tick) ? 7'h0 : hcnt_reg + 7'h1;
            raw_reg       <= running && (raw_reg ^ half_tick);
            hdiv_reg      <= !running ? 3'h0 : hdiv_reg + {2'h0, half_tick};
            settle_reg    <= (state_reg != lfo_pkg::LFO_SETTLE) ? 3'h0 : settle_reg + {2'h0, half_tick && !raw_reg};
            osc.ready     <= (state_next == lfo_pkg::LFO_RUN);
            osc.out_level <= running && (osc.out_level ^ out_tgl);
            osc.rise      <= out_tgl && !osc.out_level;
            osc.fall      <= out_tgl && osc.out_level;
        end
    end

    property p_half_period;
        @(posedge pclk) disable iff (!presetn)
        running && $stable(osc.trim) |-> hcnt_reg < half_len;
    endproperty
    a_half_period: assert property (p_half_period) else $error("half period overrun");

    property p_divider;
        @(posedge pclk) disable iff (!presetn)
        running && $stable(osc.div_sel) && osc.div_sel == 2'b11 && half_tick |=> osc.out_level != $past(osc.out_level);
    endproperty
    a_divider: assert property (p_divider) else $error("divide by one missed a toggle");
endmodule

// *** src/lfo_ctrl_top.sv ***
// oscillator control registers, capture timers and interrupt logic on APB
`timescale 1ns/1ps
`include "lfo_defs.svh"
module lfo_ctrl_top
#(
    parameter logic [4:0] HF_TRIM_RESET = `LFO_HF_TRIM_RESET  // arbitrary stand-in for the factory value
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic      [4:0]  hf_period_trim,
    output logic             lf_osc_enable,
    output logic      [3:0]  lf_freq_trim,
    output logic      [1:0]  lf_divider_select,
    output logic             lf_osc_stable_flag,
    output logic             lf_clk_out
);
    lfo_osc_if osc ();

    logic [4:0]            hf_trim_reg;
    logic [7:0]            lf_ctrl_reg;
    logic [1:0]            cap_ctrl_reg;
    logic [15:0]           count_a_reg;
    logic [15:0]           count_b_reg;
    logic [15:0]           reload_a_reg;
    logic [15:0]           reload_b_reg;
    logic [`LFO_IRQ_W-1:0] stat_reg;
    logic [`LFO_IRQ_W-1:0] stat_next;
    logic [`LFO_IRQ_W-1:0] irq_en_reg;
    logic [`LFO_IRQ_W-1:0] stat_set;
    logic [`LFO_IRQ_W-1:0] stat_clr;
    logic                  ready_d_reg;
    logic                  pready_reg;
    logic [31:0]           prdata_reg;
    logic                  pslverr_reg;
    logic                  irq_reg;
    logic                  after_reset_reg;

    logic [7:0]            idx;
    logic                  setup;
    logic                  wr_go;
    logic                  hit;
    logic [31:0]           rd_word;
    logic [7:0]            wbyte;
    logic                  cap_a;
    logic                  cap_b;
    logic                  wr_lf;
    logic                  wr_hf;
    logic                  wr_en;
    logic                  wr_clr;
    logic                  wr_cap;

    // word index of an aligned register; high address bits must be zero
    function automatic logic is_reg(input logic [7:0] i);
        is_reg = (i == `LFO_IDX_LF_CTRL) || (i == `LFO_IDX_HF_TRIM) || (i[7:3] == 5'h18);
    endfunction

    // 8-bit registers live in the low lane, so only that strobe counts
    assign idx    = paddr[9:2];
    assign hit    = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && is_reg(idx);
    assign setup  = psel && !penable;
    assign wr_go  = psel && penable && pready_reg && pwrite && hit && pstrb[0];
    assign wbyte  = pwdata[7:0];
    assign wr_lf  = wr_go && (idx == `LFO_IDX_LF_CTRL);
    assign wr_hf  = wr_go && (idx == `LFO_IDX_HF_TRIM);
    assign wr_en  = wr_go && (idx == `LFO_IDX_IRQ_EN);
    assign wr_clr = wr_go && (idx == `LFO_IDX_IRQ_CLR);
    assign wr_cap = wr_go && (idx == `LFO_IDX_CAP_CTRL);

    // read mux; the stable flag is live state, never the stored bit
    always_comb
    begin
        rd_word = 32'h0;
        unique case (idx)
            `LFO_IDX_LF_CTRL:  rd_word[7:0] = {lf_ctrl_reg[7], osc.ready && lf_ctrl_reg[7], lf_ctrl_reg[5:0]};
            `LFO_IDX_HF_TRIM:  rd_word[7:0] = {3'h0, hf_trim_reg};
            `LFO_IDX_IRQ_STAT: rd_word[`LFO_IRQ_W-1:0] = stat_reg;
            `LFO_IDX_IRQ_EN:   rd_word[`LFO_IRQ_W-1:0] = irq_en_reg;
            `LFO_IDX_CAP_CTRL: rd_word[1:0] = cap_ctrl_reg;
            `LFO_IDX_RELOAD_A: rd_word[15:0] = reload_a_reg;
            `LFO_IDX_RELOAD_B: rd_word[15:0] = reload_b_reg;
            `LFO_IDX_COUNT_A:  rd_word[15:0] = count_a_reg;
            `LFO_IDX_COUNT_B:  rd_word[15:0] = count_b_reg;
            default:           rd_word = 32'h0;
        endcase
    end

    // no wait state: answer registered in setup, shown through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= setup;
            prdata_reg  <= (setup && !pwrite && hit) ? rd_word : 32'h0;
            pslverr_reg <= setup && !hit;
        end
    end

    // control registers; the ready bit position is dropped on write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lf_ctrl_reg     <= `LFO_LF_CTRL_RESET;
            hf_trim_reg     <= HF_TRIM_RESET;
            irq_en_reg      <= '0;
            cap_ctrl_reg    <= 2'h0;
            after_reset_reg <= 1'b1;
        end
        else
        begin
            if (wr_lf)
                lf_ctrl_reg <= {wbyte[7], 1'b0, wbyte[5:0]};
            if (wr_hf)
                hf_trim_reg <= wbyte[`LFO_HF_TRIM_W-1:0];
            if (wr_en)
                irq_en_reg <= wbyte[`LFO_IRQ_W-1:0];
            if (wr_cap)
                cap_ctrl_reg <= wbyte[1:0];
            after_reset_reg <= 1'b0;
        end
    end

    // drive the oscillator model from the stored fields
    assign osc.enable  = lf_ctrl_reg[`LFO_LF_EN_BIT];
    assign osc.trim    = lf_ctrl_reg[`LFO_LF_TRIM_LSB+3:`LFO_LF_TRIM_LSB];
    assign osc.div_sel = lf_ctrl_reg[`LFO_LF_DIV_LSB+1:`LFO_LF_DIV_LSB];

    lfo_osc_core u_core
    (
        .pclk    (pclk),
        .presetn (presetn),
        .osc     (osc)
    );

    // timer A watches falling edges, timer B rising edges
    assign cap_a = cap_ctrl_reg[0] && osc.fall;
    assign cap_b = cap_ctrl_reg[1] && osc.rise;

    // free-running counts on the known time base; captures snapshot them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_a_reg  <= 16'h0;
            count_b_reg  <= 16'h0;
            reload_a_reg <= 16'h0;
            reload_b_reg <= 16'h0;
        end
        else
        begin
            count_a_reg <= cap_ctrl_reg[0] ? count_a_reg + 16'h1 : 16'h0;
            count_b_reg <= cap_ctrl_reg[1] ? count_b_reg + 16'h1 : 16'h0;
            if (cap_a)
                reload_a_reg <= count_a_reg;
            if (cap_b)
                reload_b_reg <= count_b_reg;
        end
    end

    // sticky events; a set in the clear cycle survives
    assign stat_set  = {osc.ready && !ready_d_reg, cap_b, cap_a};
    assign stat_clr  = wr_clr ? wbyte[`LFO_IRQ_W-1:0] : '0;
    assign stat_next = (stat_reg & ~stat_clr) | stat_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_reg    <= '0;
            ready_d_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end
        else
        begin
            stat_reg    <= stat_next;
            ready_d_reg <= osc.ready;
            irq_reg     <= |(stat_next & (wr_en ? wbyte[`LFO_IRQ_W-1:0] : irq_en_reg));
        end
    end

    // every output straight from a flop
    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign irq                = irq_reg;
    assign hf_period_trim     = hf_trim_reg;
    assign lf_osc_enable      = lf_ctrl_reg[`LFO_LF_EN_BIT];
    assign lf_freq_trim       = lf_ctrl_reg[`LFO_LF_TRIM_LSB+3:`LFO_LF_TRIM_LSB];
    assign lf_divider_select  = lf_ctrl_reg[`LFO_LF_DIV_LSB+1:`LFO_LF_DIV_LSB];
    assign lf_osc_stable_flag = osc.ready;
    assign lf_clk_out         = osc.out_level;

    // checks next to the logic they guard
    property p_hf_read;
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == {2'h0, `LFO_IDX_HF_TRIM, 2'h0}
            |=> prdata[31:5] == 27'h0 && prdata[4:0] == hf_period_trim;
    endproperty
    a_hf_read: assert property (p_hf_read) else $error("hf trim read wrong");

    property p_hf_reset;
        @(posedge pclk) disable iff (!presetn)
        after_reset_reg |-> hf_period_trim == HF_TRIM_RESET;
    endproperty
    a_hf_reset: assert property (p_hf_reset) else $error("hf trim reset value wrong");

    property p_enable_write;
        @(posedge pclk) disable iff (!presetn)
        wr_lf |=> lf_osc_enable == $past(pwdata[7]) && lf_divider_select == $past(pwdata[1:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("lf control write lost");

    property p_trim_write;
        @(posedge pclk) disable iff (!presetn)
        wr_lf |=> lf_freq_trim == $past(pwdata[5:2]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("lf trim write lost");

    property p_div_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_lf |=> $stable(lf_divider_select);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divider select changed");

    property p_capture_flag;
        @(posedge pclk) disable iff (!presetn)
        cap_a |=> stat_reg[`LFO_IRQ_CAP_A] ##1 1'b1;
    endproperty
    a_capture_flag: assert property (p_capture_flag) else $error("capture A not flagged");

    property p_capture_edge;
        @(posedge pclk) disable iff (!presetn)
        cap_ctrl_reg[1] && $rose(lf_clk_out) |-> cap_b;
    endproperty
    a_capture_edge: assert property (p_capture_edge) else $error("rising edge not captured");

    property p_reload_copy;
        @(posedge pclk) disable iff (!presetn)
        cap_b |=> reload_b_reg == $past(count_b_reg);
    endproperty
    a_reload_copy: assert property (p_reload_copy) else $error("reload B not copied");

    property p_ready_off;
        @(posedge pclk) disable iff (!presetn)
        !lf_osc_enable |=> !lf_osc_stable_flag;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while disabled");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        |(stat_reg & irq_en_reg) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

    c_ready:   cover property (@(posedge pclk) disable iff (!presetn) $rose(lf_osc_stable_flag));
    c_cap_a:   cover property (@(posedge pclk) disable iff (!presetn) cap_a ##[1:400] cap_a);
    c_clr_set: cover property (@(posedge pclk) disable iff (!presetn) wr_clr && |stat_set);
endmodule

// *** tb/test_lf_osc_control_and_hf_trim.sv ***
// self-checking bench for the oscillator control block, registers reached over apb
`timescale 1ns/1ps
`include "lfo_defs.svh"
module test_lf_osc_control_and_hf_trim;
    localparam logic [4:0] HF_RST = 5'h0b;  // arbitrary stand-in for the factory value
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [4:0]  hf_period_trim;
    logic        lf_osc_enable;
    logic [3:0]  lf_freq_trim;
    logic [1:0]  lf_divider_select;
    logic        lf_osc_stable_flag;
    logic        lf_clk_out;
    int          failures;
    int          total_checks;
    integer      seed;
    int          m_lf;
    int          m_hf;
    logic [31:0] rd;
    logic [31:0] a1;
    logic        err;
    int          n;
    int          tt;

    lfo_ctrl_top #(.HF_TRIM_RESET(HF_RST)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .hf_period_trim(hf_period_trim), .lf_osc_enable(lf_osc_enable),
        .lf_freq_trim(lf_freq_trim), .lf_divider_select(lf_divider_select),
        .lf_osc_stable_flag(lf_osc_stable_flag), .lf_clk_out(lf_clk_out));

    // 10 MHz bench clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; pready and read data are taken at the rising edge, before that edge's updates land
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        if (pready !== 1'b1)
            check(32'h0, 32'h1, "apb answer missing");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write and keep the behavioural register model in step
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(adr(idx), 1'b1, d, 4'hf, rd, err);
        if (idx == `LFO_IDX_LF_CTRL)
            m_lf = d & 32'hbf;
        if (idx == `LFO_IDX_HF_TRIM)
            m_hf = d & 32'h1f;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        apb(adr(idx), 1'b0, 32'h0, 4'h0, rd, err);
        check(rd, exp, msg);
    endtask

    // waits on the falling pclk edge until the lf output shows lv; c counts cycles waited
    task automatic wait_lf(input logic lv, output int c);
        c = 0;
        while (lf_clk_out !== lv && c < 2000)
        begin
            @(negedge pclk);
            c++;
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge pclk);
    endtask

    // watchdog: the tests need well under 60k cycles
    initial
    begin
        repeat (100000) @(posedge pclk);
        failures++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        presetn = 1'b0;
        failures = 0;
        total_checks = 0;
        seed = 32'hd4bbefe3;
        m_lf = 0;
        m_hf = HF_RST;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        rchk(`LFO_IDX_LF_CTRL, 32'h0, "lf control reset");
        rchk(`LFO_IDX_HF_TRIM, 32'(HF_RST), "hf trim reset");
        check(32'(hf_period_trim), 32'(HF_RST), "hf trim port reset");
        rchk(`LFO_IDX_IRQ_STAT, 32'h0, "status reset");
        $display("test reset values done");
        // hf trim: random fields, unused upper bits, dropped byte strobe
        repeat (4)
        begin
            wr(`LFO_IDX_HF_TRIM, $random(seed));
            rchk(`LFO_IDX_HF_TRIM, 32'(m_hf), "hf trim readback");
            check(32'(hf_period_trim), 32'(m_hf), "hf trim port");
        end
        apb(adr(`LFO_IDX_HF_TRIM), 1'b1, ~32'(m_hf), 4'h0, rd, err);
        rchk(`LFO_IDX_HF_TRIM, 32'(m_hf), "hf trim after masked write");
        // refused accesses leave the registers alone
        apb(12'h000, 1'b0, 32'h0, 4'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        apb(adr(`LFO_IDX_LF_CTRL) + 12'h1, 1'b1, 32'hff, 4'hf, rd, err);
        check(32'(err), 32'h1, "misaligned write");
        apb(12'he18, 1'b1, 32'hff, 4'hf, rd, err);
        check(32'(err), 32'h1, "high address write");
        rchk(`LFO_IDX_LF_CTRL, 32'h0, "lf control after refused writes");
        rchk(`LFO_IDX_IRQ_CLR, 32'h0, "clear register reads zero");
        $display("test hf trim and refusals done");
        // stable flag: not writable, rises after enable, raises the interrupt
        wr(`LFO_IDX_LF_CTRL, 32'h40);
        rchk(`LFO_IDX_LF_CTRL, 32'h0, "flag write while off");
        check(32'(lf_osc_stable_flag), 32'h0, "flag port while off");
        wr(`LFO_IDX_LF_CTRL, 32'h80 | 32'(2'b11));
        n = 0;
        while (lf_osc_stable_flag !== 1'b1 && n < 3000)
        begin
            @(negedge pclk);
            n++;
        end
        check(32'(lf_osc_stable_flag), 32'h1, "flag after enable");
        rchk(`LFO_IDX_LF_CTRL, 32'(m_lf) | 32'h40, "lf control stable");
        rchk(`LFO_IDX_IRQ_STAT, 32'h4, "ready event");
        check(32'(irq), 32'h0, "irq masked");
        wr(`LFO_IDX_IRQ_EN, 32'h4);
        cycles(2);
        check(32'(irq), 32'h1, "irq enabled");
        wr(`LFO_IDX_IRQ_CLR, 32'h4);
        cycles(2);
        check(32'(irq), 32'h0, "irq cleared");
        rchk(`LFO_IDX_IRQ_STAT, 32'h0, "status cleared");
        wr(`LFO_IDX_LF_CTRL, 32'h80 | 32'(2'b11));
        rchk(`LFO_IDX_LF_CTRL, 32'(m_lf) | 32'h40, "flag kept across write");
        wr(`LFO_IDX_LF_CTRL, 32'h0);
        cycles(2);
        check(32'(lf_osc_stable_flag), 32'h0, "flag after disable");
        rchk(`LFO_IDX_LF_CTRL, 32'h0, "lf control off");
        $display("test stable flag and interrupt done");
        // every divider code at fastest, slowest and a random trim
        for (int d = 0; d < 4; d++)
        begin
            for (int j = 0; j < 3; j++)
            begin
                tt = (j == 0) ? 0 : (j == 1) ? 15 : ($random(seed) & 15);
                wr(`LFO_IDX_LF_CTRL, 32'h80 | 32'(tt << 2) | 32'(d));
                cycles(1);
                check(32'({lf_osc_enable, lf_freq_trim, lf_divider_select}),
                      32'(((m_lf & 32'h80) >> 1) | (m_lf & 32'h3f)), "lf fields");
                wait_lf(1'b0, n);
                wait_lf(1'b1, n);
                wait_lf(1'b0, n);
                wait_lf(1'b1, n);
                wait_lf(1'b0, n);
                check(32'(n), 32'((`LFO_HALF_CYC + tt) * (8 >> d)), "lf half period");
            end
        end
        $display("test divider and trim done");
        // capture: two successive captures differ by one lf period
        wr(`LFO_IDX_LF_CTRL, 32'h80 | 32'(5 << 2) | 32'h2);
        wr(`LFO_IDX_IRQ_EN, 32'h3);
        wr(`LFO_IDX_CAP_CTRL, 32'h3);
        // timer A needs a falling edge seen before each read, timer B a rising one
        for (int b = 0; b < 2; b++)
        begin
            wait_lf(1'(~b), n);
            wait_lf(1'(b), n);
            apb(adr(`LFO_IDX_RELOAD_A + 8'(b)), 1'b0, 32'h0, 4'h0, a1, err);
            wait_lf(1'(~b), n);
            wait_lf(1'(b), n);
            apb(adr(`LFO_IDX_RELOAD_A + 8'(b)), 1'b0, 32'h0, 4'h0, rd, err);
            check(rd - a1, 32'((`LFO_HALF_CYC + 5) * 2 * 2), "capture spacing");
        end
        rchk(`LFO_IDX_IRQ_STAT, 32'h7, "capture events");
        check(32'(irq), 32'h1, "capture irq");
        wr(`LFO_IDX_CAP_CTRL, 32'h0);
        wr(`LFO_IDX_IRQ_CLR, 32'h7);
        cycles(2);
        check(32'(irq), 32'h0, "capture irq cleared");
        rchk(`LFO_IDX_IRQ_STAT, 32'h0, "no capture when off");
        $display("test capture done");
        stop_test();
    end
endmodule
